// ==== rtl/port_ctl_pkg.sv ====
// Constants, mode decoding and register layout for the bus control port block
// Function
// - Port B direction bit: 0 input, 1 output, for GPIO pins; resets 0
// - Port B carries low address and data lines; GPIO only in single chip modes
// - Port B direction register hidden in expanded and peripheral modes
// - Port E data hidden in peripheral mode, or expanded with emulate bit
// - Port E direction bits 7..2 select direction; bits 1..0 read zero, input only
// - Selected alternate bus function overrides the port E direction bit
// - Function select reset value depends on operating mode
// - Peripheral mode refuses function select access; clock test bit resets to one
// - Bit 7 picks bus enable or inverted E, else calibration or GPIO
// - Bus enable, pipe and strobe bits: write once normal, skip first special
// - Clock test bit never writable normal; routes test clock to pin 6 except single chip, normal expanded, or expanded with pipe enabled
// - Pipe enable in expanded modes drives queue status on pins 6 and 5
// - No E clock bit: once normal single, free special single, else never
// - Pin 4 is E clock unless disabled; input in peripheral mode
// - Strobe enable drives pin 3 except single chip and normal narrow
// - One pull-up bit enables pull-ups on pins 7,3,2,1,0 when inputs
package port_ctl_pkg;
    localparam logic [15:0] OFS_PORT_B_DIRECTION = 16'h0003;
    localparam logic [15:0] OFS_PORT_E_DATA = 16'h0008;
    localparam logic [15:0] OFS_PORT_E_DIRECTION = 16'h0009;
    localparam logic [15:0] OFS_PORT_E_FUNCTION_SELECT = 16'h000a;

    localparam int BIT_NO_DATA_BUS_ENABLE = 7;
    localparam int BIT_CLOCK_TEST_ENABLE = 6;
    localparam int BIT_PIPE_OUTPUT_ENABLE = 5;
    localparam int BIT_NO_E_CLOCK = 4;
    localparam int BIT_LOW_STROBE_ENABLE = 3;
    localparam int BIT_READ_WRITE_PIN_ENABLE = 2;
    localparam int BIT_CALIBRATION_ENABLE = 1;
    localparam int BIT_BUS_ENABLE_OR_INVERTED_E_SELECT = 0;

    localparam logic [7:0] RST_PORT_B_DIRECTION = 8'h00;
    localparam logic [7:0] RST_PORT_E_DATA = 8'h00;
    localparam logic [7:0] RST_PORT_E_DIRECTION = 8'h00;
    localparam logic [7:0] RST_FSEL_NORMAL_EXPANDED = 8'h00;
    localparam logic [7:0] RST_FSEL_SPECIAL = 8'h2c;
    localparam logic [7:0] RST_FSEL_PERIPHERAL = 8'hd0;
    localparam logic [7:0] RST_FSEL_NORMAL_SINGLE = 8'h90;
    localparam logic [7:0] PORT_E_DIR_MASK = 8'hfc;
    localparam logic [7:0] PORT_E_PULLUP_MASK = 8'h8f;
    // Write-once class: bus enable, pipe, strobe, read/write, bus enable select
    localparam logic [7:0] FSEL_ONCE_MASK = 8'had;

    // Operating mode code on mode_i: {normal, mode_select_b, mode_select_a}
    localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
    localparam logic [2:0] MODE_SPECIAL_NARROW = 3'h1;
    localparam logic [2:0] MODE_PERIPHERAL = 3'h2;
    localparam logic [2:0] MODE_SPECIAL_WIDE = 3'h3;
    localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
    localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
    localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

    function automatic logic is_periph(input logic [2:0] m);
        return m == MODE_PERIPHERAL;
    endfunction
    // Unused code 6 falls back to normal single chip
    function automatic logic is_single(input logic [2:0] m);
        return m == MODE_SPECIAL_SINGLE || m == MODE_NORMAL_SINGLE || m == 3'h6;
    endfunction
    function automatic logic is_special(input logic [2:0] m);
        return !m[2];
    endfunction
    function automatic logic is_expanded(input logic [2:0] m);
        return !is_single(m) && !is_periph(m);
    endfunction
    function automatic logic is_normal_expanded(input logic [2:0] m);
        return m == MODE_NORMAL_NARROW || m == MODE_NORMAL_WIDE;
    endfunction
    function automatic logic [7:0] fsel_reset(input logic [2:0] m);
        if (is_periph(m)) begin
            return RST_FSEL_PERIPHERAL;
        end else if (is_special(m)) begin
            return RST_FSEL_SPECIAL;
        end else if (is_normal_expanded(m)) begin
            return RST_FSEL_NORMAL_EXPANDED;
        end
        return RST_FSEL_NORMAL_SINGLE;
    endfunction
endpackage

// ==== rtl/bus_control_port_assignment.sv ====
// Port B direction, port E data and direction, and port E function selection
`timescale 1ns/1ps
module bus_control_port_assignment #(
    parameter int ADDR_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    output logic ext_access_o,
    input wire logic [2:0] mode_i,
    input wire logic emulate_port_e_i,
    input wire logic e_stretch_i,
    input wire logic pull_up_e_i,
    input wire logic [7:0] port_b_latch_i,
    input wire logic [7:0] bus_ab_out_i,
    input wire logic bus_ab_oe_i,
    input wire logic [7:0] port_b_pins_i,
    output logic [7:0] port_b_pins_o,
    output logic [7:0] port_b_pins_oe_o,
    input wire logic data_bus_enable_i,
    input wire logic e_clock_i,
    input wire logic calibration_i,
    input wire logic queue_status_1_i,
    input wire logic queue_status_0_i,
    input wire logic clock_test_i,
    input wire logic low_strobe_i,
    input wire logic read_write_i,
    input wire logic [7:0] port_e_pins_i,
    output logic [7:0] port_e_pins_o,
    output logic [7:0] port_e_pins_oe_o,
    output logic [7:0] port_e_pullup_o
);
    logic [7:0] port_b_direction_r;
    logic [7:0] port_e_data_r;
    logic [7:0] port_e_direction_r;
    logic [7:0] port_e_function_select_r;
    logic [7:0] fsel_nxt;
    logic init_done_r;
    logic fsel_written_r;
    logic hit_port_b_direction, hit_pe_data, hit_pe_dir, hit_fsel, hit_any;
    logic single, special, periph, expanded, normal_exp;
    logic [7:0] alt_sel, alt_out, alt_oe;
    logic [7:0] pe_out_nxt, pe_oe_nxt, pe_read;
    logic [7:0] pb_out_nxt, pb_oe_nxt;
    logic [7:0] rd_nxt;

    assign single = port_ctl_pkg::is_single(mode_i);
    assign special = port_ctl_pkg::is_special(mode_i);
    assign periph = port_ctl_pkg::is_periph(mode_i);
    assign expanded = port_ctl_pkg::is_expanded(mode_i);
    assign normal_exp = port_ctl_pkg::is_normal_expanded(mode_i);

    // Register visibility; hidden registers become external accesses
    assign hit_port_b_direction = addr_i == ADDR_W'(port_ctl_pkg::OFS_PORT_B_DIRECTION) && single;
    assign hit_pe_data = addr_i == ADDR_W'(port_ctl_pkg::OFS_PORT_E_DATA)
                         && !periph && !(expanded && emulate_port_e_i);
    assign hit_pe_dir = addr_i == ADDR_W'(port_ctl_pkg::OFS_PORT_E_DIRECTION)
                        && !periph && !(expanded && emulate_port_e_i);
    assign hit_fsel = addr_i == ADDR_W'(port_ctl_pkg::OFS_PORT_E_FUNCTION_SELECT) && !periph;
    assign hit_any = hit_port_b_direction || hit_pe_data || hit_pe_dir || hit_fsel;
    assign ext_access_o = (rd_i || wr_i) && !hit_any;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_b_direction_r <= port_ctl_pkg::RST_PORT_B_DIRECTION;
        end else if (wr_i && hit_port_b_direction) begin
            port_b_direction_r <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_e_data_r <= port_ctl_pkg::RST_PORT_E_DATA;
            port_e_direction_r <= port_ctl_pkg::RST_PORT_E_DIRECTION;
        end else begin
            if (wr_i && hit_pe_data) begin
                port_e_data_r <= wr_data_i;
            end
            if (wr_i && hit_pe_dir) begin
                port_e_direction_r <= wr_data_i & port_ctl_pkg::PORT_E_DIR_MASK;
            end
        end
    end

    // Write permission per bit class for the function select register
    always_comb begin
        logic [7:0] wmask;
        wmask = 8'h00;
        if (special) begin
            if (fsel_written_r) begin
                wmask = port_ctl_pkg::FSEL_ONCE_MASK;
                wmask[port_ctl_pkg::BIT_CLOCK_TEST_ENABLE] = 1'b1;
            end
        end else if (!fsel_written_r) begin
            wmask = port_ctl_pkg::FSEL_ONCE_MASK;
        end
        if (mode_i == port_ctl_pkg::MODE_SPECIAL_SINGLE) begin
            wmask[port_ctl_pkg::BIT_NO_E_CLOCK] = 1'b1;
        end else if (port_ctl_pkg::is_single(mode_i) && !special) begin
            wmask[port_ctl_pkg::BIT_NO_E_CLOCK] = !fsel_written_r;
        end
        wmask[port_ctl_pkg::BIT_CALIBRATION_ENABLE] = 1'b1;
        fsel_nxt = (port_e_function_select_r & ~wmask) | (wr_data_i & wmask);
    end

    // Mode-dependent value is loaded on the first edge after release
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_done_r <= 1'b0;
            fsel_written_r <= 1'b0;
            port_e_function_select_r <= port_ctl_pkg::RST_FSEL_NORMAL_EXPANDED;
        end else if (!init_done_r) begin
            init_done_r <= 1'b1;
            port_e_function_select_r <= port_ctl_pkg::fsel_reset(mode_i);
        end else if (wr_i && hit_fsel) begin
            fsel_written_r <= 1'b1;
            port_e_function_select_r <= fsel_nxt;
        end
    end

    // Alternate function selection, ahead of the direction bits
    always_comb begin
        logic [7:0] f;
        f = port_e_function_select_r;
        alt_sel = 8'h00;
        alt_out = 8'h00;
        alt_oe = 8'h00;
        if (expanded && !f[port_ctl_pkg::BIT_NO_DATA_BUS_ENABLE]) begin
            alt_sel[7] = 1'b1;
            alt_oe[7] = 1'b1;
            alt_out[7] = f[port_ctl_pkg::BIT_BUS_ENABLE_OR_INVERTED_E_SELECT] ? !e_clock_i : data_bus_enable_i;
        end else if (f[port_ctl_pkg::BIT_CALIBRATION_ENABLE]) begin
            alt_sel[7] = 1'b1;
            alt_oe[7] = 1'b1;
            alt_out[7] = calibration_i;
        end
        if (expanded && f[port_ctl_pkg::BIT_PIPE_OUTPUT_ENABLE]) begin
            alt_sel[6:5] = 2'b11;
            alt_oe[6:5] = 2'b11;
            alt_out[6:5] = {queue_status_1_i, queue_status_0_i};
        end else if (f[port_ctl_pkg::BIT_CLOCK_TEST_ENABLE] && !single && !normal_exp) begin
            alt_sel[6] = 1'b1;
            alt_oe[6] = 1'b1;
            alt_out[6] = clock_test_i;
        end
        if (!f[port_ctl_pkg::BIT_NO_E_CLOCK] && !(single && e_stretch_i)) begin
            alt_sel[4] = 1'b1;
            alt_oe[4] = !periph;
            alt_out[4] = e_clock_i;
        end
        if (f[port_ctl_pkg::BIT_LOW_STROBE_ENABLE] && !single && mode_i != port_ctl_pkg::MODE_NORMAL_NARROW) begin
            alt_sel[3] = 1'b1;
            alt_oe[3] = 1'b1;
            alt_out[3] = low_strobe_i;
        end
        if (f[port_ctl_pkg::BIT_READ_WRITE_PIN_ENABLE] && !single) begin
            alt_sel[2] = 1'b1;
            alt_oe[2] = 1'b1;
            alt_out[2] = read_write_i;
        end
        alt_sel[1:0] = 2'b11;
    end

    always_comb begin
        pe_out_nxt = (alt_sel & alt_out) | (~alt_sel & port_e_data_r);
        pe_oe_nxt = (alt_sel & alt_oe) | (~alt_sel & port_e_direction_r);
        // Inputs show the pin, GPIO outputs show the latch
        pe_read = (~alt_sel & port_e_direction_r & port_e_data_r)
                  | ~(~alt_sel & port_e_direction_r) & port_e_pins_i;
        // Peripheral mode also hands port B to the bus
        if (!single) begin
            pb_out_nxt = bus_ab_out_i;
            pb_oe_nxt = {8{bus_ab_oe_i}};
        end else begin
            pb_out_nxt = port_b_latch_i;
            pb_oe_nxt = port_b_direction_r;
        end
    end

    // Pins are registered so every pad output comes from a flop
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_b_pins_o <= 8'h00;
            port_b_pins_oe_o <= 8'h00;
            port_e_pins_o <= 8'h00;
            port_e_pins_oe_o <= 8'h00;
            port_e_pullup_o <= 8'h00;
        end else begin
            port_b_pins_o <= pb_out_nxt;
            port_b_pins_oe_o <= pb_oe_nxt;
            port_e_pins_o <= pe_out_nxt;
            port_e_pins_oe_o <= pe_oe_nxt;
            port_e_pullup_o <= {8{pull_up_e_i}} & ~pe_oe_nxt & port_ctl_pkg::PORT_E_PULLUP_MASK;
        end
    end

    always_comb begin
        rd_nxt = 8'h00;
        if (hit_port_b_direction) begin
            rd_nxt = port_b_direction_r;
        end else if (hit_pe_data) begin
            rd_nxt = pe_read;
        end else if (hit_pe_dir) begin
            rd_nxt = port_e_direction_r;
        end else if (hit_fsel) begin
            rd_nxt = port_e_function_select_r;
        end
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_i) begin
            rd_data_o <= rd_nxt;
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_second_fsel_write;
        init_done_r && fsel_written_r && wr_i && hit_fsel && !special;
    endsequence

    chk_pb_gpio_dir: assert property (
        single && $past(single) && $past(init_done_r) |-> port_b_pins_oe_o == $past(port_b_direction_r))
        else $error("port B enable does not follow direction register");
    chk_pb_bus_map: assert property (
        !single |=> port_b_pins_o == $past(bus_ab_out_i))
        else $error("port B does not carry the bus address and data");
    chk_port_b_direction_hidden: assert property (
        wr_i && !single && addr_i == ADDR_W'(port_ctl_pkg::OFS_PORT_B_DIRECTION)
        |-> ext_access_o ##1 $stable(port_b_direction_r))
        else $error("hidden port B direction register was accessed on chip");
    chk_pe_data_hidden: assert property (
        rd_i && addr_i == ADDR_W'(port_ctl_pkg::OFS_PORT_E_DATA) && (periph || expanded && emulate_port_e_i)
        |-> ext_access_o ##1 rd_data_o == 8'h00)
        else $error("hidden port E data register answered on chip");
    chk_pe_low_input: assert property (
        port_e_pins_oe_o[1:0] == 2'b00 && port_e_direction_r[1:0] == 2'b00)
        else $error("interrupt pins of port E driven or direction set");
    chk_dbe_override: assert property (
        expanded && init_done_r && !port_e_function_select_r[port_ctl_pkg::BIT_NO_DATA_BUS_ENABLE]
        |=> port_e_pins_oe_o[7])
        else $error("bus enable pin not driven despite selection");
    chk_fsel_init: assert property (
        !init_done_r |=> port_e_function_select_r == port_ctl_pkg::fsel_reset($past(mode_i)))
        else $error("function select reset value wrong for mode");
    chk_periph_locked: assert property (
        periph && init_done_r && wr_i && addr_i == ADDR_W'(port_ctl_pkg::OFS_PORT_E_FUNCTION_SELECT)
        |-> ext_access_o ##1 $stable(port_e_function_select_r))
        else $error("function select changed in peripheral mode");
    chk_once_normal: assert property (
        seq_second_fsel_write |=> (port_e_function_select_r & port_ctl_pkg::FSEL_ONCE_MASK)
        == ($past(port_e_function_select_r) & port_ctl_pkg::FSEL_ONCE_MASK))
        else $error("write-once bits changed on a second write");
    chk_e_clock_pin: assert property (
        init_done_r && !port_e_function_select_r[port_ctl_pkg::BIT_NO_E_CLOCK] && !single
        |=> port_e_pins_oe_o[4] == !$past(periph) && port_e_pins_o[4] == $past(e_clock_i))
        else $error("E clock pin wrong");
endmodule

// ==== sim/ext_bus_model.sv ====
// Far-side memories and peripherals sharing the port pins with the block
`timescale 1ns/1ps
module ext_bus_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] port_o_i,
    input wire logic [7:0] port_oe_i,
    input wire logic [7:0] pullup_i,
    input wire logic [7:0] drive_val_i,
    input wire logic [7:0] drive_en_i,
    output logic [7:0] pins_o
);
    logic [7:0] float_r = 8'h5a;

    // Undriven wires wander so a stale level never passes for a driven one
    always_ff @(posedge sys_clk_i) begin
        float_r <= ~float_r;
    end

    assign pins_o = (port_oe_i & port_o_i) | (~port_oe_i & drive_en_i & drive_val_i)
                  | (~port_oe_i & ~drive_en_i & (pullup_i | float_r));
endmodule

// ==== sim/tb_bus_control_port_assignment.sv ====
// Self-checking bench for the port control block against a reference model
`timescale 1ns/1ps
module tb_bus_control_port_assignment;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [2:0] mode_i = 3'h4;
    logic emulate_port_e_i = 1'b0;
    logic pull_up_e_i = 1'b0;
    logic [7:0] port_b_latch_i = 8'h00;
    // Sources: dbe, e clock, cal, queue 1, queue 0, clock test, strobe, read/write
    logic [7:0] alt_r = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] bus_ab_r = 8'h00;
    logic bus_ab_oe_r = 1'b0;
    logic [7:0] rd_data_o, port_b_pins_o, port_b_pins_oe_o, port_e_pins_o, port_e_pins_oe_o, port_e_pullup_o;
    logic [7:0] pb_pins, pe_pins;
    logic ext_access_o;
    integer mismatches = 0, num_checks = 0, cycles = 0, seed = 32'hcaf7_2d06;

    bus_control_port_assignment bus_control_port_assignment_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .ext_access_o(ext_access_o),
        .mode_i(mode_i), .emulate_port_e_i(emulate_port_e_i), .e_stretch_i(1'b0),
        .pull_up_e_i(pull_up_e_i), .port_b_latch_i(port_b_latch_i), .bus_ab_out_i(bus_ab_r),
        .bus_ab_oe_i(bus_ab_oe_r), .port_b_pins_i(pb_pins), .port_b_pins_o(port_b_pins_o),
        .port_b_pins_oe_o(port_b_pins_oe_o), .data_bus_enable_i(alt_r[7]), .e_clock_i(alt_r[6]),
        .calibration_i(alt_r[5]), .queue_status_1_i(alt_r[4]), .queue_status_0_i(alt_r[3]),
        .clock_test_i(alt_r[2]), .low_strobe_i(alt_r[1]), .read_write_i(alt_r[0]),
        .port_e_pins_i(pe_pins), .port_e_pins_o(port_e_pins_o), .port_e_pins_oe_o(port_e_pins_oe_o),
        .port_e_pullup_o(port_e_pullup_o));
    ext_bus_model ext_bus_model_e_inst (.sys_clk_i(sys_clk_i), .port_o_i(port_e_pins_o),
        .port_oe_i(port_e_pins_oe_o), .pullup_i(port_e_pullup_o), .drive_val_i(ext_val),
        .drive_en_i(ext_en), .pins_o(pe_pins));
    ext_bus_model ext_bus_model_b_inst (.sys_clk_i(sys_clk_i), .port_o_i(port_b_pins_o),
        .port_oe_i(port_b_pins_oe_o), .pullup_i(8'h00), .drive_val_i(ext_val),
        .drive_en_i(ext_en), .pins_o(pb_pins));

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic ext);
        logic e;
        addr_i <= a;
        rd_i <= 1'b1;
        #1 e = ext_access_o;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 check(rd_data_o, exp);
        check({7'h00, e}, {7'h00, ext});
        @(posedge sys_clk_i);
    endtask

    task automatic restart(input logic [2:0] m);
        rst_n_i <= 1'b0;
        mode_i <= m;
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
    endtask

    task automatic settle();
        alt_r <= 8'($random(seed));
        repeat (3) @(posedge sys_clk_i);
    endtask

    function automatic logic [7:0] fsel_rst(input logic [2:0] m);
        case (m)
            3'h2: return 8'hd0;
            3'h0, 3'h1, 3'h3: return 8'h2c;
            3'h5, 3'h7: return 8'h00;
            default: return 8'h90;
        endcase
    endfunction

    function automatic logic [7:0] fsel_next(input logic [2:0] m, input logic [7:0] cur, input logic [7:0] d,
                                             input logic first);
        logic [7:0] wm;
        wm = 8'h02;
        if (m[2] ? first : !first) wm = wm | 8'had;
        if (!m[2] && !first) wm = wm | 8'h40;
        if (m == 3'h0 || ((m == 3'h4 || m == 3'h6) && first)) wm = wm | 8'h10;
        return (cur & ~wm) | (d & wm);
    endfunction

    initial begin
        logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
        logic [7:0] cur, d, dir, lat, pin;
        logic first;
        for (int i = 0; i < 7; i++) begin
            restart(modes[i]);
            if (modes[i] == 3'h2) begin
                rd(16'h000a, 8'h00, 1'b1);
                wr(16'h000a, 8'h00);
                settle();
                check(port_e_pins_oe_o & 8'h50, 8'h40);
                check({7'h00, port_e_pins_o[6]}, {7'h00, alt_r[2]});
                continue;
            end
            cur = fsel_rst(modes[i]);
            rd(16'h000a, cur, 1'b0);
            first = 1'b1;
            repeat (3) begin
                d = 8'($random(seed));
                wr(16'h000a, d);
                cur = fsel_next(modes[i], cur, d, first);
                first = 1'b0;
                rd(16'h000a, cur, 1'b0);
            end
        end
        restart(3'h4);
        pull_up_e_i <= 1'b1;
        ext_en <= 8'hff;
        repeat (4) begin
            dir = 8'($random(seed));
            lat = 8'($random(seed));
            pin = 8'($random(seed));
            port_b_latch_i <= lat;
            ext_val <= pin;
            wr(16'h0003, dir);
            rd(16'h0003, dir, 1'b0);
            wr(16'h0009, dir);
            rd(16'h0009, dir & 8'hfc, 1'b0);
            wr(16'h0008, lat);
            settle();
            check(port_b_pins_oe_o, dir);
            check(port_b_pins_o & dir, lat & dir);
            check(port_e_pins_oe_o, dir & 8'hfc);
            check(port_e_pins_o & dir & 8'hfc, lat & dir & 8'hfc);
            check(port_e_pullup_o, 8'h8f & ~(dir & 8'hfc));
            rd(16'h0008, (lat & dir & 8'hfc) | (pin & ~(dir & 8'hfc)), 1'b0);
        end
        rd(16'h0004, 8'h00, 1'b1);
        restart(3'h7);
        rd(16'h0003, 8'h00, 1'b1);
        wr(16'h000a, 8'h28);
        wr(16'h000a, 8'h00);
        rd(16'h000a, 8'h28, 1'b0);
        bus_ab_r <= 8'($random(seed));
        bus_ab_oe_r <= 1'b1;
        settle();
        check(port_b_pins_o, bus_ab_r);
        check(port_b_pins_oe_o, 8'hff);
        check(port_e_pins_oe_o, 8'hf8);
        check(port_e_pins_o & 8'hf8, {alt_r[7], alt_r[4], alt_r[3], alt_r[6], alt_r[1], 3'h0});
        emulate_port_e_i <= 1'b1;
        rd(16'h0008, 8'h00, 1'b1);
        rd(16'h0009, 8'h00, 1'b1);
        wrap_up();
    end
endmodule
